/* File: rtl/timer16_pkg.sv */
// Constants shared by the prescaled 16-bit timer and its capture/compare.
// Assumes the oscillator is the only clock and twelve phases make a cycle.
package timer16_pkg;

    // ------------------------------------------------------------------
    // Machine cycle phases
    // ------------------------------------------------------------------
    localparam int unsigned OSC_DIVIDE    = 12;
    localparam logic [3:0]  PHASE_CAPTURE = 4'h0;
    localparam logic [3:0]  PHASE_FIRST   = 4'h2;
    localparam logic [3:0]  PHASE_SECOND  = 4'h8;
    localparam logic [3:0]  PHASE_LAST    = 4'(OSC_DIVIDE - 1);

    // ------------------------------------------------------------------
    // Source and prescaler selections
    // ------------------------------------------------------------------
    localparam logic [1:0] SRC_HALT     = 2'h0;
    localparam logic [1:0] SRC_OSC      = 2'h1;
    localparam logic [1:0] SRC_RESERVED = 2'h2;
    localparam logic [1:0] SRC_EXT      = 2'h3;
    localparam logic [1:0] PRE_DIV1     = 2'h0;
    localparam logic [1:0] PRE_DIV2     = 2'h1;
    localparam logic [1:0] PRE_DIV4     = 2'h2;
    localparam logic [1:0] PRE_DIV8     = 2'h3;
    localparam logic [2:0] MASK_DIV1    = 3'h0;
    localparam logic [2:0] MASK_DIV2    = 3'h1;
    localparam logic [2:0] MASK_DIV4    = 3'h3;
    localparam logic [2:0] MASK_DIV8    = 3'h7;
    localparam logic [2:0] PRESC_RESET  = 3'h0;

    // ------------------------------------------------------------------
    // Counter values, unit counts and compare actions
    // ------------------------------------------------------------------
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [15:0] COUNT_MAX     = 16'hffff;
    localparam logic [7:0]  BYTE_MAX      = 8'hff;
    localparam int unsigned CAPTURE_UNITS = 4;
    localparam int unsigned COMPARE_UNITS = 3;
    localparam logic [1:0]  ACT_NONE      = 2'h0;
    localparam logic [1:0]  ACT_SET       = 2'h1;
    localparam logic [1:0]  ACT_RESET     = 2'h2;
    localparam logic [1:0]  ACT_TOGGLE    = 2'h3;

endpackage

/* File: rtl/timer16.sv */
// Prescaled 16-bit up timer with overflow flags, capture and compare units.
// Assumes control bits are held by the register file outside, pins async.
`timescale 1ns/10ps

// --------------------------------------------------------------------------
// Pin synchroniser
// --------------------------------------------------------------------------
module sync_pin (
    input  wire logic clk_in,
    input  wire logic resetn_in,
    input  wire logic pin_in,
    output logic      level_out
);
    logic s1;
    logic s2;
    logic s3;

    // A change is taken once the second and third stages agree.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s1        <= 1'b0;
            s2        <= 1'b0;
            s3        <= 1'b0;
            level_out <= 1'b0;
        end else begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level_out <= s3;
            end
        end
    end
endmodule

module timer16
    import timer16_pkg::*;
(
    input  wire logic        CLK_IN,
    input  wire logic        RESETN_IN,
    input  wire logic        IDLE_IN,
    input  wire logic        EXTERNAL_COUNT_IN,
    input  wire logic        EXTERNAL_COUNTER_RESET_IN,
    input  wire logic [1:0]  SOURCE_SELECT_IN,
    input  wire logic [1:0]  PRESCALE_SELECT_IN,
    input  wire logic        EXTERNAL_RESET_ENABLE_IN,
    input  wire logic        OVERFLOW_IRQ_ENABLE_IN,
    input  wire logic        BYTE_OVERFLOW_IRQ_SELECT_IN,
    input  wire logic        WORD_OVERFLOW_IRQ_SELECT_IN,
    input  wire logic        BYTE_FLAG_CLEAR_IN,
    input  wire logic        WORD_FLAG_CLEAR_IN,
    input  wire logic [3:0]  CAPTURE_IN,
    input  wire logic [3:0]  CAPTURE_RISE_ENABLE_IN,
    input  wire logic [3:0]  CAPTURE_FALL_ENABLE_IN,
    input  wire logic [3:0]  CAPTURE_FLAG_CLEAR_IN,
    input  wire logic [47:0] COMPARE_VALUE_IN,
    input  wire logic [5:0]  COMPARE_ACTION_IN,
    input  wire logic [2:0]  COMPARE_FLAG_CLEAR_IN,
    output logic [7:0]       COUNT_HIGH_BYTE_OUT,
    output logic [7:0]       COUNT_LOW_BYTE_OUT,
    output logic             BYTE_OVERFLOW_FLAG_OUT,
    output logic             WORD_OVERFLOW_FLAG_OUT,
    output logic             OVERFLOW_IRQ_OUT,
    output logic [63:0]      CAPTURE_VALUE_OUT,
    output logic [3:0]       CAPTURE_FLAG_OUT,
    output logic [2:0]       COMPARE_FLAG_OUT,
    output logic [2:0]       COMPARE_PIN_OUT
);

    logic [3:0]  phase;
    logic        mc_end;
    logic        count_level;
    logic        reset_level;
    logic        reset_prev;
    logic        count_sample;
    logic        edge_early;
    logic        edge_late;
    logic        due_next;
    logic        due_later;
    logic        due_late2;
    logic        ext_due;
    logic        src_tick;
    logic [1:0]  source_prev;
    logic [1:0]  prescale_prev;
    logic        cfg_change;
    logic        ext_reset_event;
    logic        timer_clear;
    logic [2:0]  presc;
    logic [2:0]  presc_mask;
    logic        tick;
    logic [15:0] count;
    logic        low_wrap;
    logic        word_wrap;
    logic        byte_pend;
    logic        word_pend;
    logic        byte_set;
    logic        word_set;
    logic        inc_seen;

    // ------------------------------------------------------------------
    // Machine cycle sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            phase <= PHASE_CAPTURE;
        end else if (phase == PHASE_LAST) begin
            phase <= PHASE_CAPTURE;
        end else begin
            phase <= phase + 4'h1;
        end
    end

    assign mc_end = (phase == PHASE_LAST);

    // ------------------------------------------------------------------
    // External count edge detection
    // ------------------------------------------------------------------
    sync_pin u_count_sync (
        .clk_in    (CLK_IN),
        .resetn_in (RESETN_IN),
        .pin_in    (EXTERNAL_COUNT_IN),
        .level_out (count_level)
    );

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            count_sample <= 1'b0;
            edge_early   <= 1'b0;
            edge_late    <= 1'b0;
            due_next     <= 1'b0;
            due_later    <= 1'b0;
            due_late2    <= 1'b0;
        end else begin
            if (phase == PHASE_FIRST || phase == PHASE_SECOND) begin
                count_sample <= count_level;
            end
            if (phase == PHASE_FIRST) begin
                edge_early <= !count_sample && count_level;
            end
            if (phase == PHASE_SECOND) begin
                edge_late <= !count_sample && count_level;
            end
            if (mc_end) begin
                due_next  <= edge_early;
                due_later <= edge_late;
                due_late2 <= due_later;
            end
        end
    end

    // An early edge and a late edge of the cycle before never fall due together, since count_sample stays high between them; the OR loses none.
    assign ext_due  = due_next || due_late2;
    assign src_tick = mc_end && ((SOURCE_SELECT_IN == SRC_OSC) ||
                      (SOURCE_SELECT_IN == SRC_EXT && ext_due));

    // ------------------------------------------------------------------
    // External reset and prescaler
    // ------------------------------------------------------------------
    sync_pin u_reset_sync (
        .clk_in    (CLK_IN),
        .resetn_in (RESETN_IN),
        .pin_in    (EXTERNAL_COUNTER_RESET_IN),
        .level_out (reset_level)
    );

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            reset_prev    <= 1'b0;
            source_prev   <= SRC_HALT;
            prescale_prev <= PRE_DIV1;
        end else begin
            reset_prev    <= reset_level;
            source_prev   <= SOURCE_SELECT_IN;
            prescale_prev <= PRESCALE_SELECT_IN;
        end
    end

    assign ext_reset_event = EXTERNAL_RESET_ENABLE_IN &&
                             reset_level && !reset_prev;
    assign timer_clear = IDLE_IN || ext_reset_event;
    assign cfg_change  = (SOURCE_SELECT_IN != source_prev) ||
                         (PRESCALE_SELECT_IN != prescale_prev);

    always_comb begin
        unique case (PRESCALE_SELECT_IN)
            PRE_DIV1: presc_mask = MASK_DIV1;
            PRE_DIV2: presc_mask = MASK_DIV2;
            PRE_DIV4: presc_mask = MASK_DIV4;
            PRE_DIV8: presc_mask = MASK_DIV8;
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            presc <= PRESC_RESET;
        end else if (timer_clear || cfg_change) begin
            presc <= PRESC_RESET;
        end else if (src_tick) begin
            presc <= presc + 3'h1;
        end
    end

    assign tick = src_tick && !timer_clear && !cfg_change &&
                  ((presc & presc_mask) == presc_mask);

    // ------------------------------------------------------------------
    // Counter and overflow flags
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            count <= COUNT_RESET;
        end else if (timer_clear) begin
            count <= COUNT_RESET;
        end else if (tick) begin
            count <= count + 16'h0001;
        end
    end

    // Bytes are read live; a carry between two reads can tear the word.
    assign COUNT_HIGH_BYTE_OUT = count[15:8];
    assign COUNT_LOW_BYTE_OUT  = count[7:0];
    assign low_wrap  = tick && (count[7:0] == BYTE_MAX);
    assign word_wrap = tick && (count == COUNT_MAX);

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            byte_pend <= 1'b0;
            word_pend <= 1'b0;
        end else if (mc_end) begin
            byte_pend <= low_wrap;
            word_pend <= word_wrap;
        end
    end

    assign byte_set = mc_end && (byte_pend || word_pend);
    assign word_set = mc_end && word_pend;

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            BYTE_OVERFLOW_FLAG_OUT <= 1'b0;
            WORD_OVERFLOW_FLAG_OUT <= 1'b0;
        end else begin
            if (byte_set) begin
                BYTE_OVERFLOW_FLAG_OUT <= 1'b1;
            end else if (BYTE_FLAG_CLEAR_IN) begin
                BYTE_OVERFLOW_FLAG_OUT <= 1'b0;
            end
            if (word_set) begin
                WORD_OVERFLOW_FLAG_OUT <= 1'b1;
            end else if (WORD_FLAG_CLEAR_IN) begin
                WORD_OVERFLOW_FLAG_OUT <= 1'b0;
            end
        end
    end

    assign OVERFLOW_IRQ_OUT = OVERFLOW_IRQ_ENABLE_IN &&
        ((BYTE_OVERFLOW_IRQ_SELECT_IN && BYTE_OVERFLOW_FLAG_OUT) ||
         (WORD_OVERFLOW_IRQ_SELECT_IN && WORD_OVERFLOW_FLAG_OUT));

    // ------------------------------------------------------------------
    // Capture units
    // ------------------------------------------------------------------
    for (genvar g = 0; g < CAPTURE_UNITS; g++) begin : g_capture
        logic        cap_level;
        logic        cap_sample;
        logic        cap_hit;
        logic [15:0] cap_value;
        logic        cap_flag;

        sync_pin u_cap_sync (
            .clk_in    (CLK_IN),
            .resetn_in (RESETN_IN),
            .pin_in    (CAPTURE_IN[g]),
            .level_out (cap_level)
        );

        always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
            if (!RESETN_IN) begin
                cap_sample <= 1'b0;
                cap_hit    <= 1'b0;
                cap_value  <= COUNT_RESET;
                cap_flag   <= 1'b0;
            end else begin
                if (phase == PHASE_CAPTURE) begin
                    cap_sample <= cap_level;
                    cap_hit <= (CAPTURE_RISE_ENABLE_IN[g] &&
                                !cap_sample && cap_level) ||
                               (CAPTURE_FALL_ENABLE_IN[g] &&
                                cap_sample && !cap_level);
                end
                if (mc_end && cap_hit) begin
                    cap_value <= count;
                    cap_flag  <= 1'b1;
                end else if (CAPTURE_FLAG_CLEAR_IN[g]) begin
                    cap_flag <= 1'b0;
                end
            end
        end

        assign CAPTURE_VALUE_OUT[16*g +: 16] = cap_value;
        assign CAPTURE_FLAG_OUT[g]           = cap_flag;
    end

    // ------------------------------------------------------------------
    // Compare units
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            inc_seen <= 1'b0;
        end else if (mc_end) begin
            inc_seen <= tick;
        end
    end

    for (genvar g = 0; g < COMPARE_UNITS; g++) begin : g_compare
        logic       cmp_hit;
        logic [1:0] cmp_action;

        assign cmp_action = COMPARE_ACTION_IN[2*g +: 2];
        assign cmp_hit    = mc_end && inc_seen &&
                            (count == COMPARE_VALUE_IN[16*g +: 16]);

        always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
            if (!RESETN_IN) begin
                COMPARE_FLAG_OUT[g] <= 1'b0;
                COMPARE_PIN_OUT[g]  <= 1'b0;
            end else begin
                if (cmp_hit) begin
                    COMPARE_FLAG_OUT[g] <= 1'b1;
                end else if (COMPARE_FLAG_CLEAR_IN[g]) begin
                    COMPARE_FLAG_OUT[g] <= 1'b0;
                end
                if (cmp_hit) begin
                    unique case (cmp_action)
                        ACT_NONE:   COMPARE_PIN_OUT[g] <= COMPARE_PIN_OUT[g];
                        ACT_SET:    COMPARE_PIN_OUT[g] <= 1'b1;
                        ACT_RESET:  COMPARE_PIN_OUT[g] <= 1'b0;
                        ACT_TOGGLE: COMPARE_PIN_OUT[g] <= !COMPARE_PIN_OUT[g];
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RESETN_IN);

    cycle_length_a: assert property (
        mc_end |=> !mc_end [*8])
        else $error("Machine cycle shorter than twelve clocks.");

    count_rate_a: assert property (
        tick |=> !tick [*8])
        else $error("Counter advanced twice within one machine cycle.");

    count_step_a: assert property (
        (count != $past(count)) |->
        (count == $past(count) + 16'h0001 || count == COUNT_RESET))
        else $error("Counter changed by other than increment or clear.");

    halted_mode_a: assert property (
        (SOURCE_SELECT_IN == SRC_HALT && !timer_clear) |=> $stable(count))
        else $error("Counter moved while source selection is halted.");

    presc_clear_a: assert property (
        $changed(PRESCALE_SELECT_IN) |=> presc == PRESC_RESET)
        else $error("Prescaler not cleared after selection change.");

    ext_reset_a: assert property (
        ext_reset_event |=> (count == COUNT_RESET && presc == PRESC_RESET))
        else $error("External reset did not clear counter and prescaler.");

    idle_hold_a: assert property (
        IDLE_IN [*2] |-> (count == COUNT_RESET && presc == PRESC_RESET))
        else $error("Counter or prescaler running in idle.");

    byte_flag_delay_a: assert property (
        low_wrap |-> ##12 byte_set ##1 BYTE_OVERFLOW_FLAG_OUT)
        else $error("Byte overflow flag not set one cycle after wrap.");

    word_sets_byte_a: assert property (
        $rose(WORD_OVERFLOW_FLAG_OUT) |-> BYTE_OVERFLOW_FLAG_OUT)
        else $error("Word flag rose without the byte flag.");

    flag_sticky_a: assert property (
        (WORD_OVERFLOW_FLAG_OUT && !WORD_FLAG_CLEAR_IN) |=>
        WORD_OVERFLOW_FLAG_OUT)
        else $error("Word overflow flag dropped without a clear.");

    irq_gate_a: assert property (
        OVERFLOW_IRQ_OUT |-> (OVERFLOW_IRQ_ENABLE_IN &&
        (BYTE_OVERFLOW_FLAG_OUT || WORD_OVERFLOW_FLAG_OUT)))
        else $error("Interrupt raised without enable and flag.");

    word_wrap_cov: cover property (word_wrap ##13 WORD_OVERFLOW_FLAG_OUT);
    ext_count_cov: cover property (
        SOURCE_SELECT_IN == SRC_EXT && tick);
    capture_cov:   cover property ($rose(CAPTURE_FLAG_OUT[0]));
    compare_cov:   cover property ($rose(COMPARE_FLAG_OUT[0]));
    ext_reset_cov: cover property (ext_reset_event && count != COUNT_RESET);

endmodule

/* File: sim/ext_source.sv */
// Behavioural source of the external count and counter reset pins.
// Assumes its tasks are called from the falling edge of the timer clock.
`timescale 1ns/10ps
module ext_source (
    input  wire logic clk_in,
    output logic      count_out,
    output logic      reset_out
);
    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    initial begin
        count_out = 1'b0;
        reset_out = 1'b0;
    end

    // Each level is held a whole machine cycle.
    task automatic pulses(input int n);
        repeat (n) begin
            count_out = 1'b1;
            repeat (12) @(negedge clk_in);
            count_out = 1'b0;
            repeat (12) @(negedge clk_in);
        end
    endtask

    task automatic reset_edge();
        reset_out = 1'b1;
        repeat (12) @(negedge clk_in);
        reset_out = 1'b0;
        repeat (12) @(negedge clk_in);
    endtask
endmodule

/* File: sim/timer16_tb_top.sv */
// Self-checking bench for the prescaled timer; inputs change on falling edges.
// Assumes the timer package and the external pin source model.
`timescale 1ns/10ps
module timer16_tb_top
    import timer16_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        clk = 1'b0;
    logic        reset_n;
    logic        idle;
    logic [1:0]  src;
    logic [1:0]  pre;
    logic        ext_en;
    logic        irq_en;
    logic        byte_sel;
    logic        word_sel;
    logic        byte_clr;
    logic [3:0]  cap_in;
    logic [3:0]  cap_rise;
    logic [3:0]  cap_fall;
    logic [47:0] cmp_val;
    logic [5:0]  cmp_act;
    logic        ext_cnt;
    logic        ext_rst;
    logic [7:0]  cnt_hi;
    logic [7:0]  cnt_lo;
    logic [15:0] cnt;
    logic        byte_flag;
    logic        word_flag;
    logic        irq;
    logic [63:0] cap_val;
    logic [3:0]  cap_flag;
    logic [2:0]  cmp_flag;
    logic [2:0]  cmp_pin;
    int          num_errors = 0;
    int          total_checks = 0;
    int          cycles = 0;

    assign cnt = {cnt_hi, cnt_lo};
    always #2.5 clk = ~clk;

    timer16 dut_u (
        .CLK_IN                      (clk),
        .RESETN_IN                   (reset_n),
        .IDLE_IN                     (idle),
        .EXTERNAL_COUNT_IN           (ext_cnt),
        .EXTERNAL_COUNTER_RESET_IN   (ext_rst),
        .SOURCE_SELECT_IN            (src),
        .PRESCALE_SELECT_IN          (pre),
        .EXTERNAL_RESET_ENABLE_IN    (ext_en),
        .OVERFLOW_IRQ_ENABLE_IN      (irq_en),
        .BYTE_OVERFLOW_IRQ_SELECT_IN (byte_sel),
        .WORD_OVERFLOW_IRQ_SELECT_IN (word_sel),
        .BYTE_FLAG_CLEAR_IN          (byte_clr),
        .WORD_FLAG_CLEAR_IN          (1'b0),
        .CAPTURE_IN                  (cap_in),
        .CAPTURE_RISE_ENABLE_IN      (cap_rise),
        .CAPTURE_FALL_ENABLE_IN      (cap_fall),
        .CAPTURE_FLAG_CLEAR_IN       (4'h0),
        .COMPARE_VALUE_IN            (cmp_val),
        .COMPARE_ACTION_IN           (cmp_act),
        .COMPARE_FLAG_CLEAR_IN       (3'h0),
        .COUNT_HIGH_BYTE_OUT         (cnt_hi),
        .COUNT_LOW_BYTE_OUT          (cnt_lo),
        .BYTE_OVERFLOW_FLAG_OUT      (byte_flag),
        .WORD_OVERFLOW_FLAG_OUT      (word_flag),
        .OVERFLOW_IRQ_OUT            (irq),
        .CAPTURE_VALUE_OUT           (cap_val),
        .CAPTURE_FLAG_OUT            (cap_flag),
        .COMPARE_FLAG_OUT            (cmp_flag),
        .COMPARE_PIN_OUT             (cmp_pin)
    );

    ext_source src_u (
        .clk_in    (clk),
        .count_out (ext_cnt),
        .reset_out (ext_rst)
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk_word(input logic [15:0] exp, input logic [15:0] act);
        total_checks++;
        if (act !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t exp=%h act=%h", $time, exp, act);
        end
    endtask

    task automatic chk_bits(input logic [3:0] exp, input logic [3:0] act);
        total_checks++;
        if (act !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t exp=%h act=%h", $time, exp, act);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Locks onto the machine cycle, then idles twelve clocks to clear the counter and prescaler.
    task automatic align(input logic [1:0] s, input logic [1:0] p);
        logic [15:0] c;
        int          k;
        src = SRC_OSC;
        pre = PRE_DIV1;
        c   = cnt;
        k   = 0;
        @(negedge clk);
        while (cnt === c && k < 40) begin
            @(negedge clk);
            k++;
        end
        idle = 1'b1;
        src  = s;
        pre  = p;
        wait_clk(12);
        idle = 1'b0;
    endtask

    task automatic finish_test();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            num_errors++;
            finish_test();
        end
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        reset_n  = 1'b0;
        idle     = 1'b0;
        src      = SRC_HALT;
        pre      = PRE_DIV1;
        ext_en   = 1'b0;
        irq_en   = 1'b0;
        byte_sel = 1'b0;
        word_sel = 1'b0;
        byte_clr = 1'b0;
        cap_in   = 4'h0;
        cap_rise = 4'h1;
        cap_fall = 4'h2;
        cmp_val  = {16'h0007, 16'h0006, 16'h0005};
        cmp_act  = {ACT_TOGGLE, ACT_RESET, ACT_SET};
        wait_clk(12);
        reset_n = 1'b1;
        chk_word(16'h0000, cnt);
        chk_bits(4'h0, {1'b0, byte_flag, word_flag, irq});
        for (int p = 0; p < 4; p++) begin
            align(SRC_OSC, 2'(p));
            wait_clk(144);
            chk_word(16'(12 >> p), cnt);
            if (p == 0) begin
                chk_bits(4'h7, {1'b0, cmp_flag});
                chk_bits(4'h5, {1'b0, cmp_pin});
            end
        end
        pre = PRE_DIV4;
        wait_clk(1);
        pre = PRE_DIV8;
        wait_clk(71);
        chk_word(16'h0001, cnt);
        src = SRC_HALT;
        pre = PRE_DIV1;
        wait_clk(36);
        chk_word(16'h0001, cnt);
        src = SRC_RESERVED;
        wait_clk(36);
        chk_word(16'h0001, cnt);
        align(SRC_OSC, PRE_DIV1);
        irq_en   = 1'b1;
        word_sel = 1'b1;
        wait_clk(3072);
        chk_word(16'h0100, cnt);
        wait_clk(11);
        chk_bits(4'h0, {2'b00, byte_flag, irq});
        wait_clk(1);
        chk_bits(4'h2, {1'b0, word_flag, byte_flag, irq});
        byte_sel = 1'b1;
        wait_clk(1);
        chk_bits(4'h3, {2'b00, byte_flag, irq});
        irq_en = 1'b0;
        wait_clk(1);
        chk_bits(4'h2, {2'b00, byte_flag, irq});
        irq_en = 1'b1;
        wait_clk(24);
        chk_bits(4'h3, {2'b00, byte_flag, irq});
        byte_clr = 1'b1;
        wait_clk(1);
        byte_clr = 1'b0;
        chk_bits(4'h0, {2'b00, byte_flag, irq});
        align(SRC_EXT, PRE_DIV1);
        src_u.pulses(5);
        wait_clk(36);
        chk_word(16'h0005, cnt);
        cap_in = 4'h3;
        wait_clk(36);
        chk_bits(4'h1, cap_flag);
        chk_word(16'h0005, cap_val[15:0]);
        cap_in = 4'h1;
        wait_clk(36);
        chk_bits(4'h3, cap_flag);
        chk_word(16'h0005, cap_val[31:16]);
        src_u.reset_edge();
        chk_word(16'h0005, cnt);
        ext_en = 1'b1;
        src_u.reset_edge();
        chk_word(16'h0000, cnt);
        finish_test();
    end
endmodule
